//--- dv/isr_partner.sv
// Remote participant model handing parsed submessages over.
module isr_partner
	import isr_pkg::*;
(
	output logic sub_valid,
	output isr_submsg_t sub,
	input wire logic core_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {sub_valid, sub} = '0;
	// Holds one submessage for one edge, then shows its inverse.
	task automatic send(isr_submsg_t m);
		if (m.kind == ISR_KIND_TIME && m.flags[FLAG_INVALIDATE_POS])
			m.timestamp = '0;
		@(posedge core_clk) {sub_valid, sub} <= {1'h1, m};
		@(posedge core_clk) {sub_valid, sub} <= {1'h0, ~m};
		#1;
	endtask
endmodule

//--- dv/isr_receiver_props.sv
// Assertions on the receiver state ports.
module isr_receiver_props
	import isr_pkg::*;
#(
	parameter int LIST_AW = 2
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [GUID_PREFIX_W-1:0] local_prefix,
	input wire logic msg_start,
	input wire logic msg_end,
	input wire logic sub_valid,
	input wire isr_submsg_t sub,
	input wire logic sub_invalid,
	input wire logic [GUID_PREFIX_W-1:0] dest_prefix,
	input wire isr_source_t source,
	input wire logic have_timestamp,
	input wire logic [TIMESTAMP_W-1:0] timestamp,
	input wire logic [GUID_PREFIX_W+ENTITY_ID_W-1:0] reader_guid,
	input wire logic [LIST_AW:0] uc_count,
	input wire logic [LIST_AW:0] mc_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Decodes of a submessage taken away from message boundaries.
	wire logic take = sub_valid && !msg_start && !msg_end;
	wire logic dst = take && sub.kind == ISR_KIND_DEST;
	wire logic dok = dst && sub.length >= MIN_LEN_DEST;
	wire logic tim = take && sub.kind == ISR_KIND_TIME;
	wire logic inv = sub.flags[FLAG_INVALIDATE_POS];
	wire logic src = take && sub.kind == ISR_KIND_SOURCE && sub.length >= MIN_LEN_SOURCE;
	// State updates.
	short_len_a: assert property (dst && !dok |=> sub_invalid && $stable(dest_prefix))
		else $error("short kept");
	other_kind_a: assert property (take && sub.kind == ISR_KIND_OTHER |=> !sub_invalid
		&& $stable(dest_prefix) && $stable(source) && $stable(have_timestamp)) else $error("other kind");
	dest_load_a: assert property (dok && sub.guid_prefix != '0 |=> dest_prefix == $past(sub.guid_prefix))
		else $error("dest");
	dest_local_a: assert property (dok && sub.guid_prefix == '0 |=> dest_prefix == $past(local_prefix))
		else $error("local");
	reader_id_a: assert property (!srst |=> reader_guid == {$past(dest_prefix), $past(sub.reader_entity)})
		else $error("reader");
	source_load_a: assert property (src |=> source == {$past(sub.guid_prefix), $past(sub.version), $past(sub.vendor)}
		&& !have_timestamp && uc_count == 1 && mc_count == 1) else $error("source");
	time_set_a: assert property (tim && !inv && sub.length >= MIN_LEN_TIME_FULL |=> have_timestamp
		&& timestamp == $past(sub.timestamp)) else $error("stamp");
	time_clear_a: assert property (tim && inv |=> !have_timestamp)
		else $error("stamp kept");
	msg_clear_a: assert property (msg_end && !sub_valid |=> !have_timestamp && uc_count == 0 && mc_count == 0)
		else $error("message state");
	// Main scenarios.
	cover property (src);
	cover property (dok);
	cover property (tim && inv);
endmodule

bind isr_receiver isr_receiver_props #(.LIST_AW(LIST_AW)) props (.core_clk(core_clk), .srst(srst),
	.local_prefix(local_prefix), .msg_start(msg_start), .msg_end(msg_end), .sub_valid(sub_valid), .sub(sub),
	.sub_invalid(sub_invalid), .dest_prefix(dest_prefix), .source(source), .have_timestamp(have_timestamp),
	.timestamp(timestamp), .reader_guid(reader_guid), .uc_count(uc_count), .mc_count(mc_count));

//--- dv/isr_receiver_tb_top.sv
// Self-checking bench of the receiver state.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("Error %0t %h %h", $time, a, b); end end
module isr_receiver_tb_top
	import isr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0;
	logic srst = 1;
	logic msg_end = 0;
	logic msg_start = 0;
	logic lw = 0;
	logic lm = 0;
	int err_count = 0;
	int num_checks = 0;
	logic sub_valid, sub_invalid, sub_applied, have_timestamp, ok, info, exp_ht;
	logic [GUID_PREFIX_W-1:0] local_prefix, dest_prefix, exp_dest;
	isr_submsg_t sub, s;
	isr_source_t source, exp_src;
	isr_kind_t kinds[5] = '{ISR_KIND_OTHER, ISR_KIND_DEST, ISR_KIND_REPLY, ISR_KIND_SOURCE, ISR_KIND_TIME};
	logic [TIMESTAMP_W-1:0] timestamp, exp_ts;
	logic [LOCATOR_W-1:0] uc_rd_data, mc_rd_data;
	logic [127:0] reader_guid;
	logic [2:0] uc_cnt, mc_cnt;
	logic [5:0] exp_cnt;
	wire logic [5:0] cnt = {uc_cnt, mc_cnt};
	always #2 core_clk = ~core_clk;
	isr_partner peer (.core_clk(core_clk), .sub_valid(sub_valid), .sub(sub));
	isr_receiver dut (.core_clk(core_clk), .srst(srst), .local_prefix(local_prefix), .msg_start(msg_start), .msg_end(msg_end),
		.sub_valid(sub_valid), .sub(sub), .loc_wr_valid(lw), .loc_wr_mcast(lm), .loc_wr_idx(2'h0),
		.loc_wr_data({6{32'h0a0b0c0d}}), .uc_rd_idx(2'h0), .mc_rd_idx(2'h0), .sub_invalid(sub_invalid),
		.sub_applied(sub_applied), .dest_prefix(dest_prefix), .source(source), .have_timestamp(have_timestamp),
		.timestamp(timestamp), .reader_guid(reader_guid), .uc_rd_data(uc_rd_data), .mc_rd_data(mc_rd_data),
		.uc_count(uc_cnt), .mc_count(mc_cnt));
	// Least body length of a valid submessage.
	function automatic logic [15:0] min_len(isr_submsg_t m);
		if (m.kind == ISR_KIND_TIME)
			return m.flags[FLAG_INVALIDATE_POS] ? MIN_LEN_TIME_EMPTY : MIN_LEN_TIME_FULL;
		if (m.kind == ISR_KIND_REPLY)
			return 16'(LOCLIST_HDR_LEN + 16'(m.uc_count) * LOCATOR_LEN
				+ (m.flags[FLAG_MULTICAST_POS] ? 16'(LOCLIST_HDR_LEN + 16'(m.mc_count) * LOCATOR_LEN) : 16'h0000));
		return m.kind == ISR_KIND_DEST ? MIN_LEN_DEST : MIN_LEN_SOURCE;
	endfunction
	// Writes locator entry zero of one list.
	task automatic loc(logic m);
		@(posedge core_clk) {lw, lm} <= {1'h1, m};
		@(posedge core_clk) lw <= 0;
		#1;
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Cuts a hang short.
	initial
	begin
		#5000;
		err_count++;
		conclude();
	end
	// Random submessages, then reply and boundary corners.
	initial
	begin
		void'($urandom(69559));
		local_prefix = {$urandom, $urandom, $urandom};
		{exp_dest, exp_src, exp_ts, exp_ht, exp_cnt} = {local_prefix, 199'h0};
		repeat (4) @(posedge core_clk);
		srst <= 0;
		repeat (100)
		begin
			repeat (21) s = isr_submsg_t'({s[$bits(s)-33:0], $urandom});
			s.kind = kinds[$urandom % 5];
			s.length = 16'($urandom % 24);
			{s.uc_count, s.mc_count} = {8'($urandom % 2), 8'($urandom % 2)};
			if ($urandom % 4 == 0)
				s.guid_prefix = '0;
			info = s.kind != ISR_KIND_OTHER;
			ok = s.length >= min_len(s);
			peer.send(s);
			`CHK({sub_applied, sub_invalid}, {ok && info, !ok && info})
			`CHK(reader_guid, {exp_dest, s.reader_entity})
			if (ok && s.kind == ISR_KIND_REPLY)
				exp_cnt = 6'h00;
			if (ok && s.kind == ISR_KIND_DEST)
				exp_dest = s.guid_prefix != '0 ? s.guid_prefix : local_prefix;
			if (ok && s.kind == ISR_KIND_SOURCE)
				{exp_src, exp_ht, exp_cnt} = {s.guid_prefix, s.version, s.vendor, 7'h09};
			if (ok && s.kind == ISR_KIND_TIME)
				{exp_ht, exp_ts} = {!s.flags[1], s.flags[1] ? exp_ts : s.timestamp};
			`CHK({dest_prefix, source, have_timestamp, cnt}, {exp_dest, exp_src, exp_ht, exp_cnt})
			`CHK(timestamp, exp_ts)
		end
		s.kind = ISR_KIND_SOURCE;
		s.length = MIN_LEN_SOURCE;
		peer.send(s);
		@(posedge core_clk) #1 `CHK({uc_rd_data, mc_rd_data}, {2{LOCATOR_INVALID_VAL}})
		s.kind = ISR_KIND_TIME;
		s.flags = 8'h00;
		s.length = MIN_LEN_TIME_FULL;
		peer.send(s);
		s.kind = ISR_KIND_REPLY;
		s.flags = 8'h02;
		{s.uc_count, s.mc_count} = 16'h0101;
		s.length = 16'h0038;
		peer.send(s);
		`CHK(cnt, 6'h00)
		loc(0);
		loc(1);
		`CHK({have_timestamp, cnt}, 7'h49)
		@(posedge core_clk) #1 `CHK({uc_rd_data, mc_rd_data}, {12{32'h0a0b0c0d}})
		s.flags = 8'h00;
		s.length = 16'h001c;
		peer.send(s);
		loc(1);
		loc(0);
		`CHK(cnt, 6'h08)
		@(posedge core_clk) msg_end <= 1;
		@(posedge core_clk) msg_end <= 0;
		#1 `CHK({have_timestamp, cnt}, 7'h00)
		s.kind = ISR_KIND_DEST;
		s.length = MIN_LEN_DEST;
		s.guid_prefix = ~local_prefix;
		peer.send(s);
		`CHK(dest_prefix, ~local_prefix)
		@(posedge core_clk) msg_start <= 1;
		@(posedge core_clk) msg_start <= 0;
		#1 `CHK({dest_prefix, source}, {local_prefix, 128'h0})
		conclude();
	end
endmodule

//--- hw/isr_loclist.sv
// Small memory holding one reply locator list, with a registered read port.
module isr_loclist
	import isr_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int AW = 2
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clear,
	input wire logic load_invalid,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_idx,
	input wire logic [LOCATOR_W-1:0] wr_data,
	input wire logic [AW-1:0] rd_idx,
	output logic [LOCATOR_W-1:0] rd_data,
	output logic [AW:0] count
);

	logic [LOCATOR_W-1:0] mem [DEPTH];

	////////////////////////////////////////////////////////////////////////////
	// Entry storage; an invalid fill writes the invalid locator to entry zero.
	always_ff @(posedge core_clk)
	begin
		if (load_invalid)
			mem[0] <= LOCATOR_INVALID_VAL;
		else if (wr_en)
			mem[wr_idx] <= wr_data;
	end

	// Entry count; clearing empties the list, an invalid fill leaves one entry.
	always_ff @(posedge core_clk)
	begin
		if (srst || clear)
			count <= '0;
		else if (load_invalid)
			count <= (AW+1)'(1);
		else if (wr_en)
			count <= (AW+1)'(wr_idx) + (AW+1)'(1);
	end

	// Registered read port.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rd_data <= '0;
		else
			rd_data <= mem[rd_idx];
	end

endmodule

//--- hw/isr_pkg.sv
// Package with the types and constants of the info submessage receiver state block.
package isr_pkg;

	localparam int GUID_PREFIX_W = 96;
	localparam int ENTITY_ID_W = 32;
	localparam int VERSION_W = 16;
	localparam int VENDOR_W = 16;
	localparam int TIMESTAMP_W = 64;
	localparam int LOCATOR_W = 192;
	localparam int LEN_W = 16;

	// Submessage kinds as presented on the parsed input.
	typedef enum logic [2:0] {
		ISR_KIND_OTHER,
		ISR_KIND_DEST,
		ISR_KIND_REPLY,
		ISR_KIND_SOURCE,
		ISR_KIND_TIME
	} isr_kind_t;

	// Least submessage body lengths in bytes.
	localparam logic [15:0] MIN_LEN_DEST = 16'h000c;
	localparam logic [15:0] MIN_LEN_SOURCE = 16'h0014;
	localparam logic [15:0] MIN_LEN_TIME_FULL = 16'h0008;
	localparam logic [15:0] MIN_LEN_TIME_EMPTY = 16'h0000;
	localparam logic [15:0] LOCLIST_HDR_LEN = 16'h0004;
	localparam logic [15:0] LOCATOR_LEN = 16'h0018;

	// Flag bit positions in the submessage header flags.
	localparam int FLAG_MULTICAST_POS = 1;
	localparam int FLAG_INVALIDATE_POS = 1;

	localparam logic [GUID_PREFIX_W-1:0] GUID_PREFIX_UNKNOWN = 96'h0;
	localparam logic [LOCATOR_W-1:0] LOCATOR_INVALID_VAL = {32'hffffffff, 32'h0, 128'h0};

	// One parsed submessage as delivered by the framer in front of this block.
	typedef struct packed {
		isr_kind_t kind;
		logic [7:0] flags;
		logic [LEN_W-1:0] length;
		logic [GUID_PREFIX_W-1:0] guid_prefix;
		logic [VERSION_W-1:0] version;
		logic [VENDOR_W-1:0] vendor;
		logic [TIMESTAMP_W-1:0] timestamp;
		logic [7:0] uc_count;
		logic [7:0] mc_count;
		logic [LOCATOR_W-1:0] uc_locator;
		logic [LOCATOR_W-1:0] mc_locator;
		logic [ENTITY_ID_W-1:0] reader_entity;
	} isr_submsg_t;

	// Source identity state.
	typedef struct packed {
		logic [GUID_PREFIX_W-1:0] guid_prefix;
		logic [VERSION_W-1:0] version;
		logic [VENDOR_W-1:0] vendor;
	} isr_source_t;

endpackage

//--- hw/isr_receiver.sv
// Receiver state kept across the info submessages of one message.
// How it works
// - Too-short submessage length marks it invalid.
// - Known destination prefix loads destination state.
// - Unknown prefix loads local participant prefix.
// - Destination prefix names readers in later submessages.
// - Reply replaces unicast reply locator list.
// - Multicast flag copies list, else empties it.
// - Reply addressing lives only within this message.
// - Source loads prefix, version and vendor.
// - Source sets invalid locators, clears timestamp.
// - Timestamp without invalidate stores value, sets present.
// - Invalidate flag clears timestamp present.
// - Timestamp lives only within this message.
// - Reader id is destination prefix plus entity.
module isr_receiver
	import isr_pkg::*;
#(
	parameter int LIST_DEPTH = 4,
	parameter int LIST_AW = 2
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [GUID_PREFIX_W-1:0] local_prefix,
	input wire logic msg_start,
	input wire logic msg_end,
	input wire logic sub_valid,
	input wire isr_submsg_t sub,
	input wire logic loc_wr_valid,
	input wire logic loc_wr_mcast,
	input wire logic [LIST_AW-1:0] loc_wr_idx,
	input wire logic [LOCATOR_W-1:0] loc_wr_data,
	input wire logic [LIST_AW-1:0] uc_rd_idx,
	input wire logic [LIST_AW-1:0] mc_rd_idx,
	output logic sub_invalid,
	output logic sub_applied,
	output logic [GUID_PREFIX_W-1:0] dest_prefix,
	output isr_source_t source,
	output logic have_timestamp,
	output logic [TIMESTAMP_W-1:0] timestamp,
	output logic [GUID_PREFIX_W+ENTITY_ID_W-1:0] reader_guid,
	output logic [LOCATOR_W-1:0] uc_rd_data,
	output logic [LOCATOR_W-1:0] mc_rd_data,
	output logic [LIST_AW:0] uc_count,
	output logic [LIST_AW:0] mc_count
);

	////////////////////////////////////////////////////////////////////////////
	// Length checks per submessage kind.
	wire logic [15:0] uc_list_len;
	wire logic [15:0] mc_list_len;
	wire logic [15:0] reply_need;
	wire logic [15:0] time_need;
	wire logic mcast_flag;
	wire logic inval_flag;
	wire logic len_ok;
	wire logic is_info;
	wire logic take;

	assign mcast_flag = sub.flags[FLAG_MULTICAST_POS];
	assign inval_flag = sub.flags[FLAG_INVALIDATE_POS];
	assign uc_list_len = 16'(LOCLIST_HDR_LEN + 16'(sub.uc_count) * LOCATOR_LEN);
	assign mc_list_len = mcast_flag ? 16'(LOCLIST_HDR_LEN + 16'(sub.mc_count) * LOCATOR_LEN) : 16'h0000;
	assign reply_need = 16'(uc_list_len + mc_list_len);
	assign time_need = inval_flag ? MIN_LEN_TIME_EMPTY : MIN_LEN_TIME_FULL;
	// Acknowledgement and fragment submessages arrive as other kinds and are not interpreted here.
	assign is_info = (sub.kind != ISR_KIND_OTHER);
	assign len_ok = (sub.kind == ISR_KIND_DEST) ? (sub.length >= MIN_LEN_DEST) :
		(sub.kind == ISR_KIND_REPLY) ? (sub.length >= reply_need) :
		(sub.kind == ISR_KIND_SOURCE) ? (sub.length >= MIN_LEN_SOURCE) :
		(sub.kind == ISR_KIND_TIME) ? (sub.length >= time_need) : 1'b0;
	assign take = sub_valid && is_info && len_ok;

	// Message boundaries: an end clears the per-message state even when a submessage
	// arrives with it, while a submessage taken in the start cycle is the first of the
	// new message and is applied on top of the cleared state.
	// Per-kind update strobes.
	wire logic take_dest;
	wire logic take_reply;
	wire logic take_source;
	wire logic take_time;
	wire logic [GUID_PREFIX_W-1:0] next_dest_prefix;

	assign take_dest = take && (sub.kind == ISR_KIND_DEST);
	assign take_reply = take && (sub.kind == ISR_KIND_REPLY);
	assign take_source = take && (sub.kind == ISR_KIND_SOURCE);
	assign take_time = take && (sub.kind == ISR_KIND_TIME);
	assign next_dest_prefix = (sub.guid_prefix != GUID_PREFIX_UNKNOWN) ? sub.guid_prefix :
		local_prefix;

	////////////////////////////////////////////////////////////////////////////
	// Validity pulses for the submessage just presented.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			sub_invalid <= 1'b0;
			sub_applied <= 1'b0;
		end
		else
		begin
			sub_invalid <= sub_valid && is_info && !len_ok;
			sub_applied <= take;
		end
	end

	// Destination prefix; a new message starts addressed to this participant.
	always_ff @(posedge core_clk)
	begin
		if (srst || msg_end)
			dest_prefix <= local_prefix;
		else if (take_dest)
			dest_prefix <= next_dest_prefix;
		else if (msg_start)
			dest_prefix <= local_prefix;
	end

	// Source identity.
	always_ff @(posedge core_clk)
	begin
		if (srst || msg_end)
			source <= '0;
		else if (take_source)
			source <= '{sub.guid_prefix, sub.version, sub.vendor};
		else if (msg_start)
			source <= '0;
	end

	// Timestamp state, scoped to the enclosing message.
	always_ff @(posedge core_clk)
	begin
		if (srst || msg_end)
			have_timestamp <= 1'b0;
		else if (take_source)
			have_timestamp <= 1'b0;
		else if (take_time)
			have_timestamp <= !inval_flag;
		else if (msg_start)
			have_timestamp <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			timestamp <= '0;
		else if (take_time && !inval_flag)
			timestamp <= sub.timestamp;
	end

	// Reader identity for the entity id of the current later submessage.
	// The entity id is paired with the prefix in force before this submessage.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			reader_guid <= '0;
		else
			reader_guid <= {dest_prefix, sub.reader_entity};
	end

	////////////////////////////////////////////////////////////////////////////
	// Reply locator lists. A reply starts by emptying both lists; its entries
	// then stream in on the locator write port while reply_open is high.
	logic reply_open;
	logic reply_mcast;
	wire logic uc_clear;
	wire logic mc_clear;
	wire logic uc_wr;
	wire logic mc_wr;

	always_ff @(posedge core_clk)
	begin
		if (srst || msg_end)
		begin
			reply_open <= 1'b0;
			reply_mcast <= 1'b0;
		end
		else if (take_reply)
		begin
			reply_open <= 1'b1;
			reply_mcast <= mcast_flag;
		end
		else if (msg_start || sub_valid)
		begin
			reply_open <= 1'b0;
			reply_mcast <= 1'b0;
		end
	end

	// A start cycle that carries a source keeps its invalid-locator fill.
	assign uc_clear = msg_end || (msg_start && !take_source) || take_reply;
	assign mc_clear = msg_end || (msg_start && !take_source) || take_reply;
	assign uc_wr = reply_open && loc_wr_valid && !loc_wr_mcast;
	assign mc_wr = reply_open && reply_mcast && loc_wr_valid && loc_wr_mcast;

	isr_loclist #(.DEPTH(LIST_DEPTH), .AW(LIST_AW)) u_uc_list (
		.core_clk(core_clk),
		.srst(srst),
		.clear(uc_clear),
		.load_invalid(take_source),
		.wr_en(uc_wr),
		.wr_idx(loc_wr_idx),
		.wr_data(loc_wr_data),
		.rd_idx(uc_rd_idx),
		.rd_data(uc_rd_data),
		.count(uc_count)
	);

	isr_loclist #(.DEPTH(LIST_DEPTH), .AW(LIST_AW)) u_mc_list (
		.core_clk(core_clk),
		.srst(srst),
		.clear(mc_clear),
		.load_invalid(take_source),
		.wr_en(mc_wr),
		.wr_idx(loc_wr_idx),
		.wr_data(loc_wr_data),
		.rd_idx(mc_rd_idx),
		.rd_data(mc_rd_data),
		.count(mc_count)
	);

endmodule
